// File: hdc_pkg.sv
// Shared constants and carrier types of the D-channel protocoller control block.
package hdc_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_PERIOD_NS = 62500;
  localparam int BIT_CYC = BIT_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 11;
  localparam int QDEPTH = 19;
  // ==========================================================
  // Register addresses
  localparam logic [4:0] ADR_CTRL_A = 5'h02;
  localparam logic [4:0] ADR_CTRL_B = 5'h03;
  localparam logic [4:0] ADR_STATUS = 5'h03;
  localparam logic [4:0] ADR_EVENT = 5'h04;
  localparam logic [4:0] ADR_QUEUE = 5'h05;
  localparam logic [4:0] ADR_MATCH1 = 5'h06;
  localparam logic [4:0] ADR_MATCH2 = 5'h07;
  // ==========================================================
  // Codes, marks and patterns
  localparam logic [1:0] KIND_PKT = 2'h0;
  localparam logic [1:0] KIND_FIRST = 2'h1;
  localparam logic [1:0] KIND_GOOD = 2'h2;
  localparam logic [1:0] KIND_BAD = 2'h3;
  localparam logic [1:0] RXL_EMPTY = 2'h0;
  localparam logic [1:0] RXL_SOME = 2'h1;
  localparam logic [1:0] RXL_OVF = 2'h2;
  localparam logic [1:0] RXL_HIGH = 2'h3;
  localparam logic [1:0] TXL_FULL = 2'h0;
  localparam logic [1:0] TXL_MANY = 2'h1;
  localparam logic [1:0] TXL_EMPTY = 2'h2;
  localparam logic [1:0] TXL_LOW = 2'h3;
  localparam logic [4:0] RX_HIGH_MARK = 5'h0f;
  localparam logic [4:0] TX_MANY_MARK = 5'h05;
  localparam logic [4:0] TX_LOW_MARK = 5'h04;
  localparam logic [7:0] PAT_FLAG = 8'h7e;
  localparam logic [7:0] PAT_ONES = 8'hff;
  localparam logic [6:0] ALL_CALL = 7'h7f;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;
  localparam logic [3:0] STUFF_RUN = 4'h5;
  localparam logic [3:0] FLAG_RUN = 4'h6;
  localparam logic [3:0] ABORT_RUN = 4'h7;
  localparam logic [3:0] IDLE_RUN = 4'hf;
  localparam logic [1:0] HOLD = 2'h3;
  // Event bit positions.
  localparam int EV_EOPD = 6;
  localparam int EV_TEOP = 5;
  localparam int EV_FA = 4;
  localparam int EV_TXFL = 3;
  localparam int EV_TXUN = 2;
  localparam int EV_RXFF = 1;
  localparam int EV_RXOV = 0;
  // ==========================================================
  // Types
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hdc_cpu_req_t;
  typedef struct packed {
    logic s_bit;
    logic bp_bit;
  } hdc_line_t;
  typedef struct packed {
    logic transmit_path_on;
    logic receive_path_on;
    logic address_filter_on;
    logic transmit_port_choice;
    logic receive_port_choice;
    logic interframe_fill_choice;
    logic spare;
    logic protocoller_loopback;
  } hdc_ctrl_a_t;
  typedef struct packed {
    logic [2:0] spare;
    logic raw_mode;
    logic receive_queue_clear;
    logic transmit_queue_clear;
    logic abort_tag;
    logic packet_end_tag;
  } hdc_ctrl_b_t;
  typedef struct packed {
    logic [1:0] received_byte_kind;
    logic [1:0] receive_queue_level;
    logic [1:0] transmit_queue_level;
    logic idle;
    logic event_pending;
  } hdc_status_t;
  typedef enum logic [2:0] {
    TX_FILL = 3'b000,
    TX_FLAG = 3'b001,
    TX_DATA = 3'b010,
    TX_FCS = 3'b011,
    TX_ABORT = 3'b100
  } hdc_tx_st_t;
endpackage

// File: hdc_queue.sv
// Byte queue with registered head output, used for both directions.
`timescale 1ns/100ps
module hdc_queue #(
  parameter int W = 10,
  parameter int D = 19
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic push,
  input wire logic [W-1:0] wdat,
  input wire logic pop,
  // State
  output logic [W-1:0] head,
  output logic [$clog2(D+1)-1:0] count
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D+1);
  localparam logic [PW-1:0] LAST = PW'(D - 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [W-1:0] q;
  } hdc_q_st_t;
  hdc_q_st_t r_r, r_nxt;
  logic do_push, do_pop;

  always_comb begin
    r_nxt = r_r;
    // Pushing into a full queue is dropped here, even with a pop in the same cycle; only the receive caller reports it, when not popping.
    do_push = push && (r_r.cnt != CW'(D));
    do_pop = pop && (r_r.cnt != '0);
    if (do_push) begin
      r_nxt.mem[r_r.wp] = wdat;
      r_nxt.wp = (r_r.wp == LAST) ? '0 : r_r.wp + 1'b1;
    end
    if (do_pop) begin
      r_nxt.rp = (r_r.rp == LAST) ? '0 : r_r.rp + 1'b1;
    end
    r_nxt.cnt = r_r.cnt + CW'(do_push) - CW'(do_pop);
    if (clr) begin
      r_nxt.wp = '0;
      r_nxt.rp = '0;
      r_nxt.cnt = '0;
    end
    r_nxt.q = r_nxt.mem[r_nxt.rp];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign head = r_r.q;
  assign count = r_r.cnt;
endmodule

// File: hdc_rxdet.sv
// Receive bit-level detector: flags, aborts, idle and stuffed-zero removal.
`timescale 1ns/100ps
module hdc_rxdet
  import hdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Serial input
  input wire logic tick,
  input wire logic bit_in,
  input wire logic raw_mode,
  // Detections
  output logic flag,
  output logic abort,
  output logic dv,
  output logic dbit,
  output logic idle
);
  localparam int PIPE = 7;
  typedef struct packed {
    logic [3:0] ones;
    logic [PIPE-1:0] pbit;
    logic [PIPE-1:0] pvld;
    logic flag;
    logic abort;
    logic dv;
    logic dbit;
    logic idle;
  } hdc_det_st_t;
  hdc_det_st_t r_r, r_nxt;

  // ==========================================================
  // Bits are held seven deep so that the start of a flag is never
  // handed on as data once the flag is recognised.
  always_comb begin
    r_nxt = r_r;
    r_nxt.flag = 1'b0;
    r_nxt.abort = 1'b0;
    r_nxt.dv = 1'b0;
    if (tick) begin
      if (raw_mode) begin
        r_nxt.dv = 1'b1;
        r_nxt.dbit = bit_in;
        r_nxt.ones = '0;
        r_nxt.pvld = '0;
      end else begin
        r_nxt.dv = r_r.pvld[0];
        r_nxt.dbit = r_r.pbit[0];
        r_nxt.pbit = {bit_in, r_r.pbit[PIPE-1:1]};
        r_nxt.pvld = {1'b1, r_r.pvld[PIPE-1:1]};
        if (bit_in) begin
          if (r_r.ones != IDLE_RUN) begin
            r_nxt.ones = r_r.ones + 1'b1;
          end
          r_nxt.abort = (r_r.ones == ABORT_RUN - 1'b1);
        end else begin
          r_nxt.ones = '0;
          r_nxt.pvld[PIPE-1] = (r_r.ones != STUFF_RUN);
          if (r_r.ones == FLAG_RUN) begin
            r_nxt.flag = 1'b1;
            r_nxt.pvld = '0;
            r_nxt.dv = 1'b0;
          end
        end
        if (r_nxt.abort) begin
          r_nxt.pvld = '0;
        end
      end
      r_nxt.idle = (r_nxt.ones == IDLE_RUN);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign flag = r_r.flag;
  assign abort = r_r.abort;
  assign dv = r_r.dv;
  assign dbit = r_r.dbit;
  assign idle = r_r.idle;
endmodule

// File: hdc_dchan_ctrl.sv
// D-channel protocoller: registers, transmit framer, receive deframer.
`timescale 1ns/100ps
module hdc_dchan_ctrl
  import hdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Microprocessor port
  input wire hdc_pkg::hdc_cpu_req_t cpu,
  output logic [7:0] cpu_rdata,
  // Line and backplane D-channel
  input wire hdc_pkg::hdc_line_t rx_line,
  output hdc_pkg::hdc_line_t tx_line,
  // Mode straps from the rest of the device
  input wire logic nt_mode,
  input wire logic channel_access_request
);
  import hdc_pkg::*;
  localparam int CW = $clog2(QDEPTH + 1);

  typedef struct packed {
    hdc_ctrl_a_t ca;
    hdc_ctrl_b_t cb;
    logic [7:0] mask;
    logic [7:0] ev;
    logic [7:0] adr1;
    logic [7:0] adr2;
    logic [7:0] rdata;
    logic ovf;
    logic [DIV_W-1:0] div;
    logic tick;
    hdc_tx_st_t ts;
    logic [7:0] tsh;
    logic [2:0] tbit;
    logic [3:0] tones;
    logic tinf;
    logic tfcs2;
    logic tend;
    logic tabt;
    logic [15:0] tcrc;
    logic [15:0] fcs;
    logic txb;
    logic [7:0] rsh;
    logic [2:0] rbit;
    logic rhunt;
    logic rinf;
    logic rfirst;
    logic [1:0] hcnt;
    logic [7:0] h0;
    logic [7:0] h1;
    logic [7:0] h2;
    logic [15:0] rcrc;
    hdc_line_t txo;
  } hdc_st_t;
  hdc_st_t r_r, r_nxt;

  logic tq_clr, tq_push, tq_pop, rq_clr, rq_push, rq_pop;
  logic [9:0] tq_wdat, tq_head, rq_wdat, rq_head;
  logic [CW-1:0] tq_cnt, rq_cnt;
  logic det_flag, det_abort, det_dv, det_dbit, det_idle, rx_bit;

  // Reflected CRC-16 advanced by one bit.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  // ==========================================================
  // Queues and receive detector
  hdc_queue #(.W(10), .D(QDEPTH)) u_txq (
    .clk_sys(clk_sys), .rst_n(rst_n), .clr(tq_clr), .push(tq_push),
    .wdat(tq_wdat), .pop(tq_pop), .head(tq_head), .count(tq_cnt)
  );
  hdc_queue #(.W(10), .D(QDEPTH)) u_rxq (
    .clk_sys(clk_sys), .rst_n(rst_n), .clr(rq_clr), .push(rq_push),
    .wdat(rq_wdat), .pop(rq_pop), .head(rq_head), .count(rq_cnt)
  );

  // Loopback takes the framer's own bit, ahead of the port choice.
  assign rx_bit = !r_r.ca.receive_path_on ? 1'b1 :
                  r_r.ca.protocoller_loopback ? r_r.txb :
                  r_r.ca.receive_port_choice ? rx_line.s_bit : rx_line.bp_bit;

  hdc_rxdet u_det (
    .clk_sys(clk_sys), .rst_n(rst_n), .tick(r_r.tick), .bit_in(rx_bit),
    .raw_mode(r_r.cb.raw_mode), .flag(det_flag), .abort(det_abort),
    .dv(det_dv), .dbit(det_dbit), .idle(det_idle)
  );

  always_comb begin
    hdc_status_t st;
    logic [7:0] fillpat;
    logic [7:0] rs;
    logic [15:0] c;
    logic want;
    logic [9:0] wdat;
    logic txbit;
    logic addr_ok;
    st = '0;
    fillpat = r_r.ca.interframe_fill_choice ? PAT_FLAG : PAT_ONES;
    rs = {det_dbit, r_r.rsh[7:1]};
    c = crc_step(r_r.tcrc, r_r.tsh[0]);
    want = 1'b0;
    wdat = '0;
    addr_ok = 1'b1;
    txbit = 1'b1;
    r_nxt = r_r;
    tq_clr = 1'b0;
    tq_push = 1'b0;
    tq_pop = 1'b0;
    tq_wdat = {r_r.cb.abort_tag, r_r.cb.packet_end_tag, cpu.wdata};
    rq_clr = 1'b0;
    rq_pop = 1'b0;
    rq_push = 1'b0;
    rq_wdat = '0;

    // ==========================================================
    // Status and bit-rate divider
    st.received_byte_kind = (rq_cnt == '0) ? KIND_PKT : rq_head[9:8];
    st.receive_queue_level = (rq_cnt == '0) ? RXL_EMPTY : r_r.ovf ? RXL_OVF :
                             (rq_cnt >= CW'(RX_HIGH_MARK)) ? RXL_HIGH : RXL_SOME;
    st.transmit_queue_level = (tq_cnt == CW'(QDEPTH)) ? TXL_FULL :
                              (tq_cnt == '0) ? TXL_EMPTY :
                              (tq_cnt >= CW'(TX_MANY_MARK)) ? TXL_MANY : TXL_LOW;
    st.idle = det_idle;
    st.event_pending = |(r_r.ev & r_r.mask);
    r_nxt.tick = (r_r.div == DIV_W'(BIT_CYC - 1));
    r_nxt.div = r_nxt.tick ? '0 : r_r.div + 1'b1;

    // ==========================================================
    // Register port
    r_nxt.cb.receive_queue_clear = 1'b0;
    r_nxt.cb.transmit_queue_clear = 1'b0;
    if (r_r.cb.receive_queue_clear) begin
      rq_clr = 1'b1;
      r_nxt.ovf = 1'b0;
      r_nxt.rhunt = 1'b1;
      r_nxt.rinf = 1'b0;
    end
    tq_clr = r_r.cb.transmit_queue_clear;
    if (cpu.wr) begin
      case (cpu.addr)
        ADR_CTRL_A: r_nxt.ca = cpu.wdata;
        ADR_CTRL_B: r_nxt.cb = cpu.wdata;
        ADR_EVENT: r_nxt.mask = cpu.wdata;
        ADR_QUEUE: begin
          tq_push = 1'b1;
          r_nxt.cb.abort_tag = 1'b0;
          r_nxt.cb.packet_end_tag = 1'b0;
        end
        ADR_MATCH1: r_nxt.adr1 = cpu.wdata;
        ADR_MATCH2: r_nxt.adr2 = cpu.wdata;
        default: ;
      endcase
    end
    if (cpu.rd) begin
      case (cpu.addr)
        ADR_CTRL_A: r_nxt.rdata = r_r.ca;
        ADR_STATUS: r_nxt.rdata = st;
        ADR_EVENT: begin
          r_nxt.rdata = r_r.ev;
          r_nxt.ev = '0;
        end
        ADR_QUEUE: begin
          r_nxt.rdata = rq_head[7:0];
          rq_pop = (rq_cnt != '0);
          if (rq_pop) begin
            r_nxt.ovf = 1'b0;
          end
        end
        ADR_MATCH1: r_nxt.rdata = r_r.adr1;
        ADR_MATCH2: r_nxt.rdata = r_r.adr2;
        default: r_nxt.rdata = '0;
      endcase
    end

    // ==========================================================
    // Transmit framer, one bit per tick
    if (r_r.tick) begin
      // A check byte ending in five ones still needs its zero ahead of the closing flag.
      if ((r_r.ts == TX_DATA || r_r.ts == TX_FCS ||
           (r_r.ts == TX_FLAG && !r_r.tinf && r_r.tbit == 3'h0)) && !r_r.cb.raw_mode &&
          r_r.tones == STUFF_RUN) begin
        r_nxt.txb = 1'b0;
        r_nxt.tones = '0;
      end else begin
        r_nxt.txb = r_r.tsh[0];
        r_nxt.tsh = r_r.tsh >> 1;
        r_nxt.tbit = r_r.tbit + 1'b1;
        r_nxt.tones = !r_r.tsh[0] ? '0 :
                      (r_r.tones == STUFF_RUN) ? STUFF_RUN : r_r.tones + 1'b1;
        if (r_r.ts == TX_DATA) begin
          r_nxt.tcrc = c;
        end
        if (r_r.tbit == 3'h7) begin
          case (r_r.ts)
            TX_FILL: begin
              r_nxt.tsh = fillpat;
              if (tq_cnt != '0 && r_r.ca.transmit_path_on) begin
                if (r_r.cb.raw_mode) begin
                  r_nxt.ts = TX_DATA;
                  tq_pop = 1'b1;
                end else begin
                  r_nxt.ts = TX_FLAG;
                  r_nxt.tsh = PAT_FLAG;
                  r_nxt.tinf = 1'b1;
                  r_nxt.tcrc = CRC_INIT;
                end
              end
            end
            TX_FLAG: begin
              if (r_r.tinf && tq_cnt != '0) begin
                r_nxt.ts = TX_DATA;
                tq_pop = 1'b1;
              end else if (r_r.tinf) begin
                r_nxt.ts = TX_ABORT;
                r_nxt.tsh = PAT_ONES;
              end else begin
                r_nxt.ts = TX_FILL;
                r_nxt.tsh = fillpat;
              end
            end
            TX_DATA: begin
              if (r_r.tabt && !r_r.cb.raw_mode) begin
                r_nxt.ts = TX_ABORT;
                r_nxt.tsh = PAT_ONES;
              end else if (r_r.tend && !r_r.cb.raw_mode) begin
                r_nxt.ts = TX_FCS;
                r_nxt.fcs = ~c;
                r_nxt.tsh = ~c[7:0];
                r_nxt.tfcs2 = 1'b0;
              end else if (tq_cnt != '0) begin
                tq_pop = 1'b1;
              end else if (r_r.cb.raw_mode) begin
                r_nxt.ts = TX_FILL;
                r_nxt.tsh = fillpat;
              end else begin
                // Running dry inside a frame ends it with an abort.
                r_nxt.ts = TX_ABORT;
                r_nxt.tsh = PAT_ONES;
                r_nxt.ev[EV_TXUN] = 1'b1;
              end
            end
            TX_FCS: begin
              r_nxt.tfcs2 = 1'b1;
              r_nxt.tsh = r_r.fcs[15:8];
              if (r_r.tfcs2) begin
                r_nxt.ts = TX_FLAG;
                r_nxt.tsh = PAT_FLAG;
                r_nxt.tinf = 1'b0;
                r_nxt.ev[EV_TEOP] = 1'b1;
              end
            end
            TX_ABORT: begin
              r_nxt.ts = TX_FILL;
              r_nxt.tsh = fillpat;
              r_nxt.tinf = 1'b0;
            end
            default: r_nxt.ts = TX_FILL;
          endcase
          if (tq_pop) begin
            r_nxt.tsh = tq_head[7:0];
            r_nxt.tend = tq_head[8];
            r_nxt.tabt = tq_head[9];
            if (tq_cnt == TX_LOW_MARK + 1'b1) begin
              r_nxt.ev[EV_TXFL] = 1'b1;
            end
          end
        end
      end
    end
    txbit = !r_r.ca.transmit_path_on | r_r.txb;
    r_nxt.txo.s_bit = (r_r.ca.transmit_port_choice && (!r_r.ca.protocoller_loopback ||
                       nt_mode || channel_access_request)) ? txbit : 1'b1;
    r_nxt.txo.bp_bit = !r_r.ca.transmit_port_choice ? txbit : 1'b1;

    // ==========================================================
    // Receive deframer; bytes wait three deep so check bytes never land
    if (det_flag) begin
      if (r_r.rinf && !r_r.rhunt && r_r.hcnt == HOLD) begin
        want = 1'b1;
        wdat = {(r_r.rcrc == CRC_GOOD) ? KIND_GOOD : KIND_BAD, r_r.h0};
        r_nxt.ev[EV_EOPD] = 1'b1;
      end
      r_nxt.rinf = 1'b1;
      r_nxt.rhunt = 1'b0;
      r_nxt.hcnt = '0;
      r_nxt.rbit = '0;
      r_nxt.rcrc = CRC_INIT;
      r_nxt.rfirst = 1'b1;
    end else if (det_abort) begin
      if (r_r.rinf && !r_r.rhunt) begin
        r_nxt.ev[EV_FA] = 1'b1;
        r_nxt.ev[EV_EOPD] = 1'b1;
      end
      r_nxt.rinf = 1'b0;
    end else if (det_dv && (r_r.cb.raw_mode || (r_r.rinf && !r_r.rhunt))) begin
      r_nxt.rsh = rs;
      r_nxt.rbit = r_r.rbit + 1'b1;
      r_nxt.rcrc = crc_step(r_r.rcrc, det_dbit);
      if (r_r.rbit == 3'h7) begin
        if (r_r.cb.raw_mode) begin
          want = 1'b1;
          wdat = {KIND_PKT, rs};
        end else begin
          case (r_r.hcnt)
            2'h0: r_nxt.h0 = rs;
            2'h1: begin
              r_nxt.h1 = rs;
              addr_ok = (!r_r.adr1[0] || r_r.h0[7:2] == r_r.adr1[7:2]) &&
                        (!r_r.adr2[0] || rs[7:1] == r_r.adr2[7:1] || rs[7:1] == ALL_CALL);
              r_nxt.rhunt = r_r.ca.address_filter_on && !addr_ok;
            end
            2'h2: r_nxt.h2 = rs;
            default: begin
              want = 1'b1;
              wdat = {r_r.rfirst ? KIND_FIRST : KIND_PKT, r_r.h0};
              r_nxt.rfirst = 1'b0;
              r_nxt.h0 = r_r.h1;
              r_nxt.h1 = r_r.h2;
              r_nxt.h2 = rs;
            end
          endcase
          r_nxt.hcnt = (r_r.hcnt == HOLD) ? HOLD : r_r.hcnt + 1'b1;
        end
      end
    end
    if (want && !r_r.cb.receive_queue_clear) begin
      if (rq_cnt == CW'(QDEPTH) && !rq_pop) begin
        r_nxt.ovf = 1'b1;
        r_nxt.ev[EV_RXOV] = 1'b1;
        r_nxt.rhunt = !r_r.cb.raw_mode;
        r_nxt.rinf = r_r.cb.raw_mode;
      end else begin
        rq_push = 1'b1;
        rq_wdat = wdat;
        if (rq_cnt == CW'(RX_HIGH_MARK - 1'b1)) begin
          r_nxt.ev[EV_RXFF] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
      // The framer idles on ones, so enabling it before the first fill reload sends no zeros.
      r_r.txb <= 1'b1;
      r_r.tsh <= PAT_ONES;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign cpu_rdata = r_r.rdata;
  assign tx_line = r_r.txo;
endmodule

// File: hdc_dchan_ctrl_monitor.sv
// Port checker of the D-channel protocoller control block, with its bind.
`timescale 1ns/100ps
module hdc_dchan_ctrl_monitor
  import hdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire hdc_pkg::hdc_cpu_req_t cpu,
  input wire logic [7:0] cpu_rdata,
  // Line and straps
  input wire hdc_pkg::hdc_line_t rx_line,
  input wire hdc_pkg::hdc_line_t tx_line,
  input wire logic nt_mode,
  input wire logic channel_access_request
);
  // Line rules hold only a full bit time after the set-up last moved.
  hdc_ctrl_a_t ctl_r;
  logic [7:0] mask_r;
  logic [10:0] quiet_r;
  wire ctl_wr = cpu.wr && cpu.addr == ADR_CTRL_A;
  wire settled = quiet_r > 11'h514;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= '0;
      mask_r <= '0;
      quiet_r <= '0;
    end else begin
      if (ctl_wr) ctl_r <= hdc_ctrl_a_t'(cpu.wdata);
      if (cpu.wr && cpu.addr == ADR_EVENT) mask_r <= cpu.wdata;
      if (ctl_wr || $changed(nt_mode) || $changed(channel_access_request)) quiet_r <= '0;
      else if (quiet_r != 11'h7ff) quiet_r <= quiet_r + 11'h001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_rdata_holds: assert property (!cpu.rd |=> $stable(cpu_rdata))
    else $error("read data moved without a read");
  a_ctrl_readback: assert property (
    cpu.rd && cpu.addr == ADR_CTRL_A |=> cpu_rdata == $past(ctl_r))
    else $error("control A read back wrong");
  a_tx_off_ones: assert property (
    settled && !ctl_r.transmit_path_on |-> tx_line == hdc_line_t'(2'h3))
    else $error("disabled transmitter not sending ones");
  a_port_unused: assert property (
    settled |-> (ctl_r.transmit_port_choice ? tx_line.bp_bit : tx_line.s_bit))
    else $error("unselected port not idle");
  a_loop_terminal: assert property (
    settled && ctl_r.protocoller_loopback && !nt_mode && !channel_access_request
    |-> tx_line.s_bit) else $error("terminal loopback reached the line");
  a_rx_clear_empty: assert property (
    cpu.wr && cpu.addr == ADR_CTRL_B && cpu.wdata[3] ##1 !cpu.wr
    ##1 cpu.rd && !cpu.wr && cpu.addr == ADR_STATUS |=> cpu_rdata[5:4] == RXL_EMPTY)
    else $error("receive queue not empty after clear");
  a_tx_clear_empty: assert property (
    cpu.wr && cpu.addr == ADR_CTRL_B && cpu.wdata[2] ##1 !cpu.wr
    ##1 cpu.rd && !cpu.wr && cpu.addr == ADR_STATUS |=> cpu_rdata[3:2] == TXL_EMPTY)
    else $error("transmit queue not empty after clear");
  a_pending_masked: assert property (
    cpu.rd && cpu.addr == ADR_STATUS && mask_r == 8'h00 |=> !cpu_rdata[0])
    else $error("pending set with all events masked");
  c_readback: cover property (cpu.rd && cpu.addr == ADR_CTRL_A);
  c_tx_clear: cover property (cpu.wr && cpu.addr == ADR_CTRL_B && cpu.wdata[2]);
  c_sending: cover property (settled && ctl_r.transmit_path_on && !tx_line.s_bit);
endmodule
bind hdc_dchan_ctrl hdc_dchan_ctrl_monitor hdc_dchan_ctrl_monitor_i (.clk_sys, .rst_n,
  .cpu, .cpu_rdata, .rx_line, .tx_line, .nt_mode, .channel_access_request);

// File: hdc_peer.sv
// Far-end D-channel peer: idle ones, or a continuous flag stream on the line side.
`timescale 1ns/100ps
module hdc_peer
  import hdc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pattern choice
  input wire logic flags_on,
  // Bits towards the block
  output hdc_pkg::hdc_line_t rx_line
);
  logic [DIV_W-1:0] div_r;
  logic [2:0] idx_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
      idx_r <= '0;
    end else if (div_r == DIV_W'(BIT_CYC - 1)) begin
      div_r <= '0;
      idx_r <= idx_r + 3'h1;
    end else begin
      div_r <= div_r + 1'h1;
    end
  end
  // Flags go out LSB first; the backplane side idles high, as a real idle channel does.
  assign rx_line.s_bit = flags_on ? PAT_FLAG[idx_r] : 1'h1;
  assign rx_line.bp_bit = 1'h1;
endmodule

// File: hdc_dchan_ctrl_bench.sv
// Self-checking bench of the D-channel protocoller control block.
`timescale 1ns/100ps
module hdc_dchan_ctrl_bench;
  import hdc_pkg::*;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  hdc_cpu_req_t cpu = '0;
  logic [7:0] cpu_rdata;
  hdc_line_t rx_line;
  hdc_line_t tx_line;
  logic nt_mode = 1'h0;
  logic channel_access_request = 1'h0;
  logic flags_on = 1'h0;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] got;
  always #25 clk_sys = ~clk_sys;
  hdc_dchan_ctrl hdc_dchan_ctrl_i (.clk_sys, .rst_n, .cpu, .cpu_rdata, .rx_line, .tx_line,
    .nt_mode, .channel_access_request);
  hdc_peer hdc_peer_i (.clk_sys, .rst_n, .flags_on, .rx_line);
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One register cycle; a read leaves its data in got.
  task automatic bus(input logic [4:0] a, input logic [7:0] d, input logic w);
    @(negedge clk_sys);
    cpu = '{addr: a, wdata: d, wr: w, rd: !w};
    @(negedge clk_sys);
    cpu.wr = 1'h0;
    cpu.rd = 1'h0;
    got = cpu_rdata;
  endtask
  // Catches the next byte on the line side, starting at its first zero bit.
  task automatic grab(output logic [7:0] b);
    int n;
    n = 0;
    b = '0;
    while (tx_line.s_bit !== 1'h0 && n < 25000) begin
      @(negedge clk_sys);
      n++;
    end
    repeat (BIT_CYC / 2) @(negedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      b[i] = tx_line.s_bit;
      repeat (BIT_CYC) @(negedge clk_sys);
    end
  endtask
  task automatic t_reset();
    bus(ADR_CTRL_A, 8'h00, 1'h0);
    chk(got, 8'h00);
    bus(ADR_STATUS, 8'h00, 1'h0);
    chk({4'h0, got[5:2]}, {4'h0, RXL_EMPTY, TXL_EMPTY});
    chk({6'h0, tx_line}, 8'h03);
    $display("reset test finished");
  endtask
  task automatic t_ctrl();
    logic [7:0] v [3] = '{8'h69, 8'h94, 8'h00};
    foreach (v[i]) begin
      bus(ADR_CTRL_A, v[i], 1'h1);
      bus(ADR_CTRL_A, 8'h00, 1'h0);
      chk(got, v[i]);
    end
    bus(ADR_EVENT, 8'h00, 1'h0);
    bus(ADR_EVENT, 8'h00, 1'h0);
    chk(got, 8'h00);
    $display("control test finished");
  endtask
  task automatic t_queues();
    for (int i = 1; i <= 20; i++) begin
      bus(ADR_QUEUE, 8'(i), 1'h1);
      bus(ADR_STATUS, 8'h00, 1'h0);
      chk({6'h0, got[3:2]}, {6'h0, i >= 19 ? TXL_FULL : i >= 5 ? TXL_MANY : TXL_LOW});
    end
    for (int k = 0; k < 2; k++) begin
      bus(ADR_CTRL_B, 8'h0c, 1'h1);
      bus(ADR_STATUS, 8'h00, 1'h0);
      chk({4'h0, got[5:2]}, {4'h0, RXL_EMPTY, TXL_EMPTY});
      bus(ADR_QUEUE, 8'h55, 1'h1);
    end
    bus(ADR_CTRL_B, 8'h04, 1'h1);
    $display("queue test finished");
  endtask
  task automatic t_line();
    bus(ADR_QUEUE, 8'h3c, 1'h1);
    bus(ADR_CTRL_B, 8'h10, 1'h1);
    bus(ADR_CTRL_A, 8'h90, 1'h1);
    grab(got);
    chk(got, 8'h3c);
    bus(ADR_CTRL_A, 8'h00, 1'h1);
    bus(ADR_CTRL_B, 8'h00, 1'h1);
    bus(ADR_CTRL_A, 8'h94, 1'h1);
    grab(got);
    chk(got, 8'h7e);
    bus(ADR_CTRL_A, 8'h00, 1'h1);
    $display("line test finished");
  endtask
  task automatic t_idle();
    bus(ADR_STATUS, 8'h00, 1'h0);
    chk({7'h0, got[1]}, 8'h01);
    flags_on = 1'h1;
    bus(ADR_CTRL_A, 8'h48, 1'h1);
    repeat (10 * BIT_CYC) @(negedge clk_sys);
    bus(ADR_STATUS, 8'h00, 1'h0);
    chk({7'h0, got[1]}, 8'h00);
    bus(ADR_CTRL_A, 8'h40, 1'h1);
    repeat (17 * BIT_CYC) @(negedge clk_sys);
    bus(ADR_STATUS, 8'h00, 1'h0);
    chk({7'h0, got[1]}, 8'h01);
    // Backplane stays all ones, so only looped-back fill flags can clear idle.
    bus(ADR_CTRL_A, 8'hd5, 1'h1);
    repeat (12 * BIT_CYC) @(negedge clk_sys);
    bus(ADR_STATUS, 8'h00, 1'h0);
    chk({7'h0, got[1]}, 8'h00);
    chk({7'h0, tx_line.s_bit}, 8'h01);
    $display("idle test finished");
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'h1;
    t_reset();
    t_ctrl();
    t_queues();
    t_line();
    t_idle();
    finish_test();
  end
  initial begin
    #5_000_000;
    fail_count++;
    finish_test();
  end
endmodule
